// >>> dv/smbus_host_model.sv
// bus host model: drives the bus clock and shares the open-drain data line
module smbus_host_model (
   // clock
   input  wire logic i_clk,
   // bus
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // clock stands high between frames, as the pull-up leaves it
   initial begin
      o_scl      = 1'b1;
      o_sda_oe_n = 1'b1;
   end
   task step(input int n);
      repeat (n) @(posedge i_clk);
   endtask : step
   // ===========================
   // bit level, 4 clocks per level gives 100 ns, so 200 ns per bit
   task bit_io(input logic b, output logic r);
      step(1);
      o_sda_oe_n <= b;
      step(3);
      o_scl <= 1'b1;
      step(4);
      r = i_sda;
      o_scl <= 1'b0;
   endtask : bit_io
   task start_cond();
      step(1);
      o_sda_oe_n <= 1'b1;
      step(3);
      o_scl <= 1'b1;
      step(4);
      o_sda_oe_n <= 1'b0;
      step(4);
      o_scl <= 1'b0;
   endtask : start_cond
   task stop_cond();
      step(1);
      o_sda_oe_n <= 1'b0;
      step(3);
      o_scl <= 1'b1;
      step(4);
      o_sda_oe_n <= 1'b1;
      step(4);
   endtask : stop_cond
   // ===========================
   // byte level, a high ack bit releases the line or ends a read
   task byte_io(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(a, k);
   endtask : byte_io
endmodule : smbus_host_model

// >>> dv/smbus_slave_pointer_ara_asserts.sv
// port checker for the serial bus slave with pointer and alert response
module smbus_slave_pointer_ara_asserts (
   // clock and reset
   input wire logic               i_clk,
   input wire logic               i_rst,
   // watched ports
   input wire smbus_pkg::strap_t  i_strap,
   input wire logic               i_scl,
   input wire logic               i_alert_cond,
   input wire logic               i_monitor_tick,
   input wire logic               i_wr_ready,
   input wire logic               o_sda_oe_n,
   input wire logic               o_alert_n,
   input wire logic [7:0]         o_reg_ptr,
   input wire logic               o_wr_valid,
   input wire smbus_pkg::wr_req_t o_wr_req,
   input wire logic [6:0]         o_own_addr,
   input wire logic               o_addr_valid,
   input wire logic               o_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   import smbus_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // ===========================
   // alert steps
   sequence s_alert_req;
      i_monitor_tick && i_alert_cond;
   endsequence
   sequence s_alert_low;
      !o_alert_n;
   endsequence
   // ===========================
   // properties
   chk_reset_vals: assert property (
      $fell(i_rst) |-> o_sda_oe_n && o_alert_n && !o_wr_valid && o_reg_ptr == 8'h00)
      else $error("outputs not at reset values");
   chk_fixed_hi: assert property (
      o_addr_valid |-> o_own_addr[6:2] == ADDR_FIXED_HI)
      else $error("upper address bits wrong");
   chk_strap_map: assert property (
      $rose(o_addr_valid) |-> o_own_addr[1:0] == (i_strap == STRAP_OPEN ? LOW_BITS_OPEN :
         i_strap == STRAP_VCC ? LOW_BITS_VCC : i_strap == STRAP_GND ? LOW_BITS_GND : LOW_BITS_BAD))
      else $error("strap decode wrong");
   chk_addr_frozen: assert property (
      o_addr_valid |=> o_addr_valid && $stable(o_own_addr))
      else $error("own address moved after capture");
   chk_alert_set: assert property (
      s_alert_req |=> s_alert_low)
      else $error("alert not raised on monitor tick");
   chk_alert_release: assert property (
      $rose(o_alert_n) |-> $past(o_busy))
      else $error("alert released outside a transfer");
   chk_wr_stand: assert property (
      o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_req))
      else $error("write request dropped before taken");
   chk_idle_release: assert property (
      !o_busy |-> o_sda_oe_n)
      else $error("data pulled while idle");
   chk_sda_on_low: assert property (
      $changed(o_sda_oe_n) |-> !i_scl)
      else $error("data moved while clock high");
endmodule : smbus_slave_pointer_ara_asserts

bind smbus_slave_pointer_ara smbus_slave_pointer_ara_asserts smbus_slave_pointer_ara_asserts_i (
   .i_clk, .i_rst, .i_strap, .i_scl, .i_alert_cond, .i_monitor_tick, .i_wr_ready, .o_sda_oe_n,
   .o_alert_n, .o_reg_ptr, .o_wr_valid, .o_wr_req, .o_own_addr, .o_addr_valid, .o_busy);

// >>> dv/smbus_slave_pointer_ara_tb.sv
// self-checking bench for the serial bus slave with pointer and alert response
module smbus_slave_pointer_ara_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import smbus_pkg::*;
   logic       i_clk, i_rst, i_alert_cond, i_monitor_tick, i_wr_ready, o_sda, o_sda_oe_n;
   logic       o_alert_n, o_wr_valid, o_addr_valid, o_busy, scl, host_oe_n, sda, ack;
   strap_t     i_strap;
   logic [7:0] i_rd_data, o_reg_ptr, rd;
   logic [6:0] o_own_addr;
   wr_req_t    o_wr_req;
   int         fail_count, checked, cycles;
   // wired-and of both open-drain parties with pull-up
   assign sda = host_oe_n & o_sda_oe_n;
   smbus_slave_pointer_ara smbus_slave_pointer_ara_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_strap(i_strap), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
      .o_sda_oe_n(o_sda_oe_n), .i_alert_cond(i_alert_cond), .i_monitor_tick(i_monitor_tick),
      .o_alert_n(o_alert_n), .o_reg_ptr(o_reg_ptr), .i_rd_data(i_rd_data), .o_wr_valid(o_wr_valid),
      .o_wr_req(o_wr_req), .i_wr_ready(i_wr_ready), .o_own_addr(o_own_addr),
      .o_addr_valid(o_addr_valid), .o_busy(o_busy));
   smbus_host_model smbus_host_model_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(host_oe_n));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // register file stand-in: content is pointer xor 5a
   always @(posedge i_clk) i_rd_data <= o_reg_ptr ^ 8'h5a;
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         final_report();
      end
   end
   // ===========================
   // helpers
   task check(input string n, input logic [16:0] s, input logic [16:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task send_addr(input logic [6:0] a, input logic rw, output logic k);
      smbus_host_model_i.start_cond();
      smbus_host_model_i.byte_io({a, rw}, 1'b1, rd, k);
   endtask : send_addr
   task final_report();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   // ===========================
   // scenarios
   task t_foreign();
      send_addr(7'h2f, 1'b0, ack);
      smbus_host_model_i.stop_cond();
      check("foreign_nack", ack, 1'b1);
   endtask : t_foreign
   task t_write_fill();
      int n;
      send_addr(7'h2e, 1'b0, ack);
      check("addr_ack", ack, 1'b0);
      smbus_host_model_i.byte_io(8'h05, 1'b1, rd, ack);
      check("ptr_ack", {ack, o_reg_ptr}, 9'h005);
      smbus_host_model_i.byte_io(8'haa, 1'b1, rd, ack);
      check("wr_req", {o_wr_valid, o_wr_req}, 17'h105aa);
      n = 0;
      // consumer stalls, so the buffer fills until a byte is refused
      while (ack === 1'b0 && n < 40) begin
         n++;
         smbus_host_model_i.byte_io(8'(n), 1'b1, rd, ack);
      end
      smbus_host_model_i.stop_cond();
      check("fill_count", n, 33);
      i_wr_ready <= 1'b1;
      n = 0;
      repeat (100) begin
         @(negedge i_clk);
         if (o_wr_valid === 1'b1) n++;
      end
      @(posedge i_clk) i_wr_ready <= 1'b0;
      check("drain_count", n, 33);
   endtask : t_write_fill
   task t_read();
      send_addr(7'h2e, 1'b0, ack);
      smbus_host_model_i.byte_io(8'h07, 1'b1, rd, ack);
      smbus_host_model_i.stop_cond();
      check("ptr_only", {o_wr_valid, o_reg_ptr}, 9'h007);
      send_addr(7'h2e, 1'b1, ack);
      smbus_host_model_i.byte_io(8'hff, 1'b1, rd, ack);
      smbus_host_model_i.stop_cond();
      check("rd_retained", rd, 8'h5d);
      send_addr(7'h2e, 1'b0, ack);
      smbus_host_model_i.byte_io(8'h09, 1'b1, rd, ack);
      send_addr(7'h2e, 1'b1, ack);
      check("rs_ack", ack, 1'b0);
      smbus_host_model_i.byte_io(8'hff, 1'b1, rd, ack);
      smbus_host_model_i.stop_cond();
      check("rd_byte", rd, 8'h53);
   endtask : t_read
   task t_ara();
      send_addr(ALERT_RESP_ADDR, 1'b1, ack);
      smbus_host_model_i.stop_cond();
      check("ara_quiet_nack", ack, 1'b1);
      i_alert_cond <= 1'b1;
      i_monitor_tick <= 1'b1;
      smbus_host_model_i.step(1);
      i_monitor_tick <= 1'b0;
      i_alert_cond <= 1'b0;
      smbus_host_model_i.step(2);
      check("alert_set", o_alert_n, 1'b0);
      // a lower address answering too pulls bit six low: back off, keep alert
      send_addr(ALERT_RESP_ADDR, 1'b1, ack);
      smbus_host_model_i.byte_io(8'h00, 1'b1, rd, ack);
      smbus_host_model_i.stop_cond();
      check("ara_lost", {rd, o_alert_n}, 9'h000);
      send_addr(ALERT_RESP_ADDR, 1'b1, ack);
      check("ara_ack", {ack, o_busy}, 2'b01);
      smbus_host_model_i.byte_io(8'hff, 1'b1, rd, ack);
      smbus_host_model_i.stop_cond();
      check("ara_reply", {rd, o_alert_n}, 9'h0b9);
   endtask : t_ara
   task t_strap();
      i_strap <= STRAP_GND;
      smbus_host_model_i.step(20);
      check("addr_held", o_own_addr, 7'h2e);
      send_addr(7'h2c, 1'b0, ack);
      smbus_host_model_i.stop_cond();
      check("new_strap_nack", ack, 1'b1);
   endtask : t_strap
   initial begin
      i_rst          = 1'b1;
      i_strap        = STRAP_OPEN;
      i_alert_cond   = 1'b0;
      i_monitor_tick = 1'b0;
      i_wr_ready     = 1'b0;
      smbus_host_model_i.step(16);
      i_rst <= 1'b0;
      smbus_host_model_i.step(8);
      check("own_addr", {o_addr_valid, o_own_addr}, 8'hae);
      check("idle_lines", {o_busy, o_sda, o_sda_oe_n}, 3'b001);
      t_foreign();
      t_write_fill();
      t_read();
      t_ara();
      t_strap();
      final_report();
   end
endmodule : smbus_slave_pointer_ara_tb

// >>> src/smbus_pkg.sv
// constants, types and enumerations shared by the serial bus slave block
//
// Overview of operation
// - answer address whose upper five bits are 01011, low two from strap
// - strap grounded gives 00, open gives 10, tied to supply gives 01
// - strap is sampled once after reset and never again until the next reset
// - after start, shift in seven address bits MSB first plus direction bit
// - on own address match, pull data low for the ninth clock
// - direction 0 means host writes, direction 1 means host reads
// - nine clocks per byte; data rising while clock high is stop
// - direction is fixed per transfer; a new start is needed to change it
// - writes carry a pointer byte then data bytes, nacked once the write buffer is full; reads return the pointed register byte, resent while the host acks
// - first written byte loads pointer, second goes to the pointed register
// - a one-byte write changes only the pointer
// - a read without pointer write returns the register the pointer selects
// - read byte via write, repeated start, then read is supported
// - while alert is low, answer alert response address with own address
// - lose arbitration on alert response and back off; lowest address wins
// - release alert after a successful alert response; reassert if it persists
package smbus_pkg;

   // ==========================================================================
   // addresses
   localparam logic [4:0] ADDR_FIXED_HI  = 5'h0b;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

   // ==========================================================================
   // strap decode
   typedef enum logic [1:0] {
      STRAP_GND  = 2'h0,
      STRAP_OPEN = 2'h1,
      STRAP_VCC  = 2'h2,
      STRAP_BAD  = 2'h3
   } strap_t;

   localparam logic [1:0] LOW_BITS_GND  = 2'h0;
   localparam logic [1:0] LOW_BITS_OPEN = 2'h2;
   localparam logic [1:0] LOW_BITS_VCC  = 2'h1;
   localparam logic [1:0] LOW_BITS_BAD  = 2'h3;
   // edges to wait after reset so the strap synchroniser holds real data
   localparam logic [1:0] STRAP_SETTLE  = 2'h3;

   // ==========================================================================
   // byte framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [7:0] PTR_RESET = 8'h00;

   // ==========================================================================
   // slave states
   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_ADDR     = 3'h1,
      ST_ADDR_ACK = 3'h2,
      ST_WR_BYTE  = 3'h3,
      ST_WR_ACK   = 3'h4,
      ST_RD_BYTE  = 3'h5,
      ST_RD_ACK   = 3'h6,
      ST_IGNORE   = 3'h7
   } slave_state_t;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic scl;
      logic sda;
   } bus_lines_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } wr_req_t;

   localparam int WR_FIFO_DEPTH = 32;

endpackage : smbus_pkg

// >>> src/smbus_slave_pointer_ara.sv
// serial bus slave with register pointer, write buffering and alert response
module smbus_slave_pointer_ara (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // address strap from the three-state pad detector
   input  wire smbus_pkg::strap_t i_strap,
   // bus pins, data is open drain
   input  wire logic              i_scl,
   input  wire logic              i_sda,
   output logic                   o_sda,
   output logic                   o_sda_oe_n,
   // alert
   input  wire logic              i_alert_cond,
   input  wire logic              i_monitor_tick,
   output logic                   o_alert_n,
   // register file side
   output logic [7:0]             o_reg_ptr,
   input  wire logic [7:0]        i_rd_data,
   output logic                   o_wr_valid,
   output smbus_pkg::wr_req_t     o_wr_req,
   input  wire logic              i_wr_ready,
   // status
   output logic [6:0]             o_own_addr,
   output logic                   o_addr_valid,
   output logic                   o_busy
);
   import smbus_pkg::*;

   // =========================================================================
   // pin synchronisers
   logic [1:0]   pin_raw;
   logic [1:0]   pin_sync;
   bus_lines_t   prev_q;
   bus_lines_t   cur;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_det;
   logic         stop_det;

   // one two-stage synchroniser per bus pin, reset high like the pulled-up lines
   assign pin_raw = {i_scl, i_sda};

   for (genvar g = 0; g < 2; g++) begin : g_pin_sync
      logic [1:0] sync_q;

      always_ff @(posedge i_clk or posedge i_rst) begin
         if (i_rst) begin
            sync_q <= 2'h3;
         end else begin
            sync_q <= {sync_q[0], pin_raw[g]};
         end
      end

      assign pin_sync[g] = sync_q[1];
   end

   assign cur = '{scl: pin_sync[1], sda: pin_sync[0]};

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prev_q <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         prev_q <= cur;
      end
   end

   assign scl_rise  = cur.scl & ~prev_q.scl;
   assign scl_fall  = ~cur.scl & prev_q.scl;
   // data edge with clock high on both samples marks start and stop
   assign start_det = cur.scl & prev_q.scl & prev_q.sda & ~cur.sda;
   assign stop_det  = cur.scl & prev_q.scl & ~prev_q.sda & cur.sda;

   // =========================================================================
   // strap capture
   strap_t       strap_sync_q [2];
   logic [1:0]   strap_cnt_q;
   logic         strap_taken_q;
   logic [1:0]   addr_low_q;
   logic [6:0]   own_addr;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         strap_sync_q[0] <= STRAP_GND;
         strap_sync_q[1] <= STRAP_GND;
      end else begin
         strap_sync_q[0] <= i_strap;
         strap_sync_q[1] <= strap_sync_q[0];
      end
   end

   // taken once; later strap moves are ignored until the next reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         strap_cnt_q   <= 2'h0;
         strap_taken_q <= 1'b0;
         addr_low_q    <= LOW_BITS_GND;
      end else if (!strap_taken_q) begin
         if (strap_cnt_q == STRAP_SETTLE) begin
            strap_taken_q <= 1'b1;
            case (strap_sync_q[1])
               STRAP_GND:  addr_low_q <= LOW_BITS_GND;
               STRAP_OPEN: addr_low_q <= LOW_BITS_OPEN;
               STRAP_VCC:  addr_low_q <= LOW_BITS_VCC;
               default:    addr_low_q <= LOW_BITS_BAD;
            endcase
         end else begin
            strap_cnt_q <= strap_cnt_q + 1'b1;
         end
      end
   end

   assign own_addr     = {ADDR_FIXED_HI, addr_low_q};
   assign o_own_addr   = own_addr;
   assign o_addr_valid = strap_taken_q;

   // =========================================================================
   // slave state
   slave_state_t state_q;
   logic [3:0]   bit_cnt_q;
   logic [7:0]   shreg_q;
   logic [7:0]   tx_q;
   logic [7:0]   tx_src;
   logic         sda_drive_q;
   logic         read_q;
   logic         ara_q;
   logic         ptr_done_q;
   logic         alert_q;
   logic [7:0]   ptr_q;
   logic         byte_end;
   logic         addr_hit;
   logic         ara_hit;
   logic         wr_end;
   logic         ptr_load;
   logic         data_push;
   logic         fifo_in_ready;
   logic         ara_done;
   logic         arb_lost;
   logic         busy_q;

   assign byte_end = scl_fall & (bit_cnt_q == BYTE_BITS) & ~start_det & ~stop_det;
   // own address only once the strap is known; foreign ones never
   assign addr_hit = strap_taken_q & (shreg_q[7:1] == own_addr);
   // alert response only answered as a read, and only while alert is low
   assign ara_hit  = alert_q & shreg_q[0] & (shreg_q[7:1] == ALERT_RESP_ADDR);
   assign wr_end    = (state_q == ST_WR_BYTE) & byte_end;
   assign ptr_load  = wr_end & ~ptr_done_q;
   assign data_push = wr_end & ptr_done_q & fifo_in_ready;
   // pointer read now, so a read without prior write sees the kept pointer
   assign tx_src    = ara_q ? {own_addr, 1'b0} : i_rd_data;
   assign ara_done  = (state_q == ST_RD_BYTE) & byte_end & ara_q;
   // we let the line float for a one but the bus reads zero
   assign arb_lost  = (state_q == ST_RD_BYTE) & scl_rise & ~sda_drive_q & ~cur.sda;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q     <= ST_IDLE;
         bit_cnt_q   <= 4'h0;
         shreg_q     <= 8'h00;
         tx_q        <= 8'h00;
         sda_drive_q <= 1'b0;
         read_q      <= 1'b0;
         ara_q       <= 1'b0;
         ptr_done_q  <= 1'b0;
      end else if (start_det) begin
         // repeated start restarts addressing in any state
         state_q     <= ST_ADDR;
         bit_cnt_q   <= 4'h0;
         sda_drive_q <= 1'b0;
         ara_q       <= 1'b0;
      end else if (stop_det) begin
         state_q     <= ST_IDLE;
         sda_drive_q <= 1'b0;
         ara_q       <= 1'b0;
      end else begin
         case (state_q)
            ST_ADDR: begin
               if (scl_rise) begin
                  shreg_q   <= {shreg_q[6:0], cur.sda};
                  bit_cnt_q <= bit_cnt_q + 1'b1;
               end else if (byte_end) begin
                  if (addr_hit || ara_hit) begin
                     state_q     <= ST_ADDR_ACK;
                     sda_drive_q <= 1'b1;
                     read_q      <= shreg_q[0];
                     ara_q       <= ara_hit & ~addr_hit;
                     ptr_done_q  <= 1'b0;
                  end else begin
                     state_q <= ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  bit_cnt_q <= 4'h0;
                  if (read_q) begin
                     state_q     <= ST_RD_BYTE;
                     tx_q        <= tx_src;
                     sda_drive_q <= ~tx_src[7];
                  end else begin
                     state_q     <= ST_WR_BYTE;
                     sda_drive_q <= 1'b0;
                  end
               end
            end
            ST_WR_BYTE: begin
               if (scl_rise) begin
                  shreg_q   <= {shreg_q[6:0], cur.sda};
                  bit_cnt_q <= bit_cnt_q + 1'b1;
               end else if (ptr_load || data_push) begin
                  state_q     <= ST_WR_ACK;
                  sda_drive_q <= 1'b1;
                  ptr_done_q  <= 1'b1;
               end else if (wr_end) begin
                  // buffer full: refuse the byte rather than lose it
                  state_q <= ST_IGNORE;
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  state_q     <= ST_WR_BYTE;
                  sda_drive_q <= 1'b0;
                  bit_cnt_q   <= 4'h0;
               end
            end
            ST_RD_BYTE: begin
               if (arb_lost) begin
                  state_q     <= ST_IGNORE;
                  sda_drive_q <= 1'b0;
               end else if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 1'b1;
               end else if (byte_end) begin
                  state_q     <= ST_RD_ACK;
                  sda_drive_q <= 1'b0;
               end else if (scl_fall) begin
                  tx_q        <= {tx_q[6:0], 1'b0};
                  sda_drive_q <= ~tx_q[6];
               end
            end
            ST_RD_ACK: begin
               if (scl_rise && cur.sda) begin
                  state_q <= ST_IGNORE;
               end else if (scl_fall) begin
                  // host wants more: resend the same register
                  state_q     <= ST_RD_BYTE;
                  bit_cnt_q   <= 4'h0;
                  tx_q        <= tx_src;
                  sda_drive_q <= ~tx_src[7];
               end
            end
            ST_IDLE, ST_IGNORE: begin
               sda_drive_q <= 1'b0;
            end
            default: begin
               state_q     <= ST_IDLE;
               sda_drive_q <= 1'b0;
            end
         endcase
      end
   end

   assign o_sda      = 1'b0;
   assign o_sda_oe_n = ~sda_drive_q;
   assign o_busy     = busy_q;

   // registered so the status pin carries no state-decode glitches
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_q != ST_IDLE);
      end
   end

   // =========================================================================
   // register pointer
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ptr_q <= PTR_RESET;
      end else if (ptr_load) begin
         ptr_q <= shreg_q;
      end
   end

   assign o_reg_ptr = ptr_q;

   // =========================================================================
   // alert output
   // a monitoring set in the same cycle as the release wins
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         alert_q <= 1'b0;
      end else if (i_monitor_tick && i_alert_cond) begin
         alert_q <= 1'b1;
      end else if (ara_done) begin
         alert_q <= 1'b0;
      end
   end

   assign o_alert_n = ~alert_q;

   // =========================================================================
   // write buffer
   wr_req_t push_req;
   wr_req_t pop_req;

   // a full buffer refuses the byte with a nack instead of stretching the clock
   assign push_req = '{addr: ptr_q, data: shreg_q};

   smbus_wr_fifo #(
      .WIDTH ($bits(wr_req_t)),
      .DEPTH (WR_FIFO_DEPTH)
   ) smbus_wr_fifo_i (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_in_valid  (data_push),
      .i_in_data   (push_req),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (o_wr_valid),
      .o_out_data  (pop_req),
      .i_out_ready (i_wr_ready)
   );

   assign o_wr_req = pop_req;

endmodule : smbus_slave_pointer_ara

// >>> src/smbus_wr_fifo.sv
// small synchronous fifo with a registered output stage
module smbus_wr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // drain side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready
);

   localparam int AW = $clog2(DEPTH);

   // pointers wrap naturally, so depth must be a power of two
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign push       = i_in_valid & o_in_ready;
   assign pop        = (cnt_q != '0) & (~o_out_valid | i_out_ready);

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         case ({push, pop})
            2'b10:   cnt_q <= cnt_q + 1'b1;
            2'b01:   cnt_q <= cnt_q - 1'b1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

   // output register: read data never come straight from the array
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_out_valid <= 1'b0;
         o_out_data  <= '0;
      end else if (pop) begin
         o_out_valid <= 1'b1;
         o_out_data  <= mem_q[rd_ptr_q];
      end else if (i_out_ready) begin
         o_out_valid <= 1'b0;
      end
   end

endmodule : smbus_wr_fifo
